// ==== hdl/sspc_ctrl.sv ====
// serial port control and status logic with an AXI4-Lite register slave
//
// Contract
// RULE_01 - one mode only: serial link or I2C
// RULE_02 - data/address flag tracks last byte kind
// RULE_03 - stop flag marks last condition was stop
// RULE_04 - start flag marks last condition was start
// RULE_05 - disabling port clears start and stop
// RULE_06 - capture read/write bit of matched address
// RULE_07 - 10-bit mode raises address refresh flag
// RULE_08 - buffer full on receive or I2C transmit
// RULE_09 - link slave overflow when buffer still full
// RULE_10 - I2C receive overflow, software clears it
// RULE_11 - enable hands clock and data pins to port
// RULE_12 - polarity selects idle level or releases clock
// RULE_13 - codes 0000-0011 master with clock divisions
// RULE_14 - codes 0100/0101 slave, select pin optional
// RULE_15 - 0110/0111 I2C slave, plus firmware master
// RULE_16 - 1110/1111 I2C slave with start/stop interrupts
// RULE_17 - write during transmit sets collision flag
// RULE_18 - one pin is clock in both modes
// RULE_19 - separate slave select pin when enabled
`timescale 1ns/1ps
module sspc_ctrl
	import sspc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [SSPC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [SSPC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire sspc_pkg::sspc_link_evt_type link_evt,
	input wire logic [7:0] link_rx_byte,
	input wire logic timer_two_output,
	output sspc_pkg::sspc_pin_type pin_ctl,
	output logic [3:0] port_mode_select,
	output logic link_is_i2c,
	output logic link_is_master,
	output logic master_bit_tick,
	output logic [7:0] tx_byte,
	output logic tx_load,
	output logic [7:0] slave_address,
	output logic cond_irq
);
	import sspc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic mode_is_i2c(input logic [3:0] m);
		mode_is_i2c = (m == MODE_I2C_S7) || (m == MODE_I2C_S10) || (m == MODE_I2C_FWM)
			|| (m == MODE_I2C_S7_INT) || (m == MODE_I2C_S10_INT);
	endfunction

	function automatic logic mode_is_10bit(input logic [3:0] m);
		mode_is_10bit = (m == MODE_I2C_S10) || (m == MODE_I2C_S10_INT);
	endfunction

	function automatic logic mode_is_master(input logic [3:0] m);
		mode_is_master = (m <= MODE_SPI_MTMR);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic write_collision_flag_q;
	logic ovf_q;
	logic en_q;
	logic ckp_q;
	logic [3:0] mode_q;
	logic da_q;
	logic stop_q;
	logic start_q;
	logic rw_q;
	logic ua_q;
	logic bf_q;
	logic [7:0] buf_q;
	logic [7:0] sadd_q;
	logic tx_busy_q;
	logic is_i2c;
	logic i2c_slave_on;

	// I2C mode decodes shared by the flag, buffer and pin paths below
	assign is_i2c = mode_is_i2c(mode_q); // [RULE_01]
	// firmware master mode keeps the slave engine idle
	assign i2c_slave_on = is_i2c && (mode_q != MODE_I2C_FWM); // [RULE_15]

	////////////////////////////////////////////////////////////////////////////////
	// axi write channel: address and data taken in either order
	logic aw_held_q;
	logic w_held_q;
	logic [SSPC_ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic wr_fire;
	logic wr_lane0;

	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wr_lane0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
		end else begin
			s_axi_awready <= !aw_held_q && !s_axi_awready;
			s_axi_wready <= !w_held_q && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wr_lane0 <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q == SSPC_CTRL_OFS || awaddr_q == SSPC_DATA_OFS
					|| awaddr_q == SSPC_ADDR_OFS || awaddr_q == SSPC_STAT_OFS)
					? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic wr_ctrl;
	logic wr_data;
	logic wr_sadd;
	assign wr_ctrl = wr_fire && wr_lane0 && (awaddr_q == SSPC_CTRL_OFS);
	assign wr_data = wr_fire && wr_lane0 && (awaddr_q == SSPC_DATA_OFS);
	assign wr_sadd = wr_fire && wr_lane0 && (awaddr_q == SSPC_ADDR_OFS);

	////////////////////////////////////////////////////////////////////////////////
	// axi read channel
	logic rd_data_ack;
	assign rd_data_ack = s_axi_arvalid && s_axi_arready && (s_axi_araddr == SSPC_DATA_OFS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= AXI_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= AXI_OKAY;
				case (s_axi_araddr)
					SSPC_CTRL_OFS: s_axi_rdata <= {24'h000000, write_collision_flag_q, ovf_q, en_q, ckp_q, mode_q};
					SSPC_STAT_OFS: s_axi_rdata <= {24'h000000, 2'h0, da_q, stop_q, start_q,
						rw_q, ua_q, bf_q};
					SSPC_DATA_OFS: s_axi_rdata <= {24'h000000, buf_q};
					SSPC_ADDR_OFS: s_axi_rdata <= {24'h000000, sadd_q};
					default: begin
						s_axi_rdata <= '0;
						s_axi_rresp <= AXI_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control register; hardware set beats software clear on the sticky bits
	logic coll_evt;
	logic ovf_evt;
	assign coll_evt = wr_data && tx_busy_q; // [RULE_17]
	// master paces its own transfers, so only slave or I2C can overrun
	assign ovf_evt = en_q && link_evt.byte_done && bf_q && !tx_busy_q
		&& (is_i2c || !mode_is_master(mode_q)); // [RULE_09] [RULE_10]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			write_collision_flag_q <= SSPC_CTRL_RST[CTL_WRITE_COLLISION_FLAG];
			ovf_q <= SSPC_CTRL_RST[CTL_OVF];
			en_q <= SSPC_CTRL_RST[CTL_EN];
			ckp_q <= SSPC_CTRL_RST[CTL_CKP];
			mode_q <= SSPC_CTRL_RST[3:0];
		end else begin
			if (wr_ctrl) begin
				write_collision_flag_q <= wdata_q[CTL_WRITE_COLLISION_FLAG];
				ovf_q <= wdata_q[CTL_OVF];
				en_q <= wdata_q[CTL_EN];
				ckp_q <= wdata_q[CTL_CKP];
				mode_q <= wdata_q[3:0];
			end
			if (coll_evt) begin
				write_collision_flag_q <= 1'b1; // [RULE_17]
			end
			if (ovf_evt) begin
				ovf_q <= 1'b1; // [RULE_10]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// data buffer, slave address, transmit tracking
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buf_q <= '0;
			sadd_q <= '0;
			tx_busy_q <= 1'b0;
		end else begin
			if (wr_sadd) begin
				sadd_q <= wdata_q[7:0];
			end
			// overrun keeps the old byte: the new shift contents are lost
			if (en_q && link_evt.byte_done && !bf_q && !tx_busy_q) begin
				buf_q <= link_rx_byte;
			end
			if (wr_data && !tx_busy_q) begin
				buf_q <= wdata_q[7:0];
			end
			if (!en_q || link_evt.tx_done) begin
				tx_busy_q <= 1'b0;
			end else if (link_evt.tx_start || (wr_data && !is_i2c)) begin
				tx_busy_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			da_q <= 1'b0;
			stop_q <= 1'b0;
			start_q <= 1'b0;
			rw_q <= 1'b0;
			ua_q <= 1'b0;
			bf_q <= 1'b0;
		end else begin
			if (!en_q) begin
				stop_q <= 1'b0; // [RULE_05]
				start_q <= 1'b0; // [RULE_05]
			end else if (i2c_slave_on && link_evt.stop_seen) begin
				stop_q <= 1'b1; // [RULE_03]
				start_q <= 1'b0;
			end else if (i2c_slave_on && link_evt.start_seen) begin
				start_q <= 1'b1; // [RULE_04]
				stop_q <= 1'b0;
			end
			if (i2c_slave_on && link_evt.byte_done) begin
				da_q <= link_evt.byte_is_data; // [RULE_02]
			end
			if (i2c_slave_on && link_evt.addr_match) begin
				rw_q <= link_evt.addr_rw; // [RULE_06]
			end else if (link_evt.start_seen || link_evt.stop_seen || link_evt.ack_seen) begin
				rw_q <= 1'b0;
			end
			if (mode_is_10bit(mode_q) && link_evt.addr_match && en_q) begin
				ua_q <= 1'b1; // [RULE_07]
			end else if (wr_sadd || !mode_is_10bit(mode_q)) begin
				ua_q <= 1'b0;
			end
			// receive completion sets, data read or transmit end clears
			if (en_q && link_evt.byte_done && !tx_busy_q) begin
				bf_q <= 1'b1; // [RULE_08]
			end else if (is_i2c && wr_data && en_q) begin
				bf_q <= 1'b1; // [RULE_08]
			end else if (rd_data_ack || link_evt.tx_done || !en_q) begin
				bf_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// master bit clock: fixed divisions or timer two halved
	logic [6:0] div_cnt_q;
	logic tmr_half_q;
	logic [6:0] div_lim;
	always_comb begin
		case (mode_q)
			MODE_SPI_M4: div_lim = 7'(DIV_F4 - 1);
			MODE_SPI_M16: div_lim = 7'(DIV_F16 - 1);
			default: div_lim = 7'(DIV_F64 - 1);
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_q <= '0;
			tmr_half_q <= 1'b0;
			master_bit_tick <= 1'b0;
		end else begin
			master_bit_tick <= 1'b0;
			if (!en_q || !mode_is_master(mode_q)) begin
				div_cnt_q <= '0;
			end else if (mode_q == MODE_SPI_MTMR) begin
				if (timer_two_output) begin
					tmr_half_q <= !tmr_half_q;
					master_bit_tick <= tmr_half_q; // [RULE_13]
				end
			end else if (div_cnt_q >= div_lim) begin
				div_cnt_q <= '0;
				master_bit_tick <= 1'b1; // [RULE_13]
			end else begin
				div_cnt_q <= div_cnt_q + 7'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin hand-over and mode outputs; direction stays with the port logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_ctl <= '0;
			port_mode_select <= '0;
			link_is_i2c <= 1'b0;
			link_is_master <= 1'b0;
			tx_byte <= '0;
			tx_load <= 1'b0;
			slave_address <= '0;
			cond_irq <= 1'b0;
		end else begin
			pin_ctl.sck_own <= en_q; // [RULE_11] [RULE_18]
			pin_ctl.sdi_own <= en_q; // [RULE_11]
			pin_ctl.sdo_own <= en_q && !is_i2c; // [RULE_11]
			pin_ctl.ss_own <= en_q && (mode_q == MODE_SPI_S_SS); // [RULE_14] [RULE_19]
			// i2c: low holds the clock to stretch, high releases it
			pin_ctl.sck_out <= ckp_q; // [RULE_12]
			pin_ctl.sdo_out <= buf_q[7];
			port_mode_select <= mode_q;
			link_is_i2c <= is_i2c; // [RULE_01]
			link_is_master <= mode_is_master(mode_q); // [RULE_13] [RULE_14]
			tx_byte <= buf_q;
			tx_load <= wr_data && !tx_busy_q && en_q;
			slave_address <= sadd_q;
			cond_irq <= en_q && (mode_q == MODE_I2C_S7_INT || mode_q == MODE_I2C_S10_INT)
				&& (link_evt.start_seen || link_evt.stop_seen); // [RULE_16]
		end
	end
endmodule

// ==== hdl/sspc_pkg.sv ====
// package: register map, field positions and types of the serial port control block
package sspc_pkg;
	localparam logic [7:0] SSPC_CTRL_OFS = 8'h14;
	localparam logic [7:0] SSPC_STAT_OFS = 8'h94;
	localparam logic [7:0] SSPC_DATA_OFS = 8'h13;
	localparam logic [7:0] SSPC_ADDR_OFS = 8'h93;
	localparam int SSPC_ADDR_W = 8;
	// control fields
	localparam int CTL_WRITE_COLLISION_FLAG = 7;
	localparam int CTL_OVF = 6;
	localparam int CTL_EN = 5;
	localparam int CTL_CKP = 4;
	// status fields
	localparam int STA_DA = 5;
	localparam int STA_STOP = 4;
	localparam int STA_START = 3;
	localparam int STA_RW = 2;
	localparam int STA_UA = 1;
	localparam int STA_BF = 0;
	localparam logic [7:0] SSPC_CTRL_RST = 8'h00;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	// master clock divisions
	localparam int DIV_F4 = 4;
	localparam int DIV_F16 = 16;
	localparam int DIV_F64 = 64;
	typedef enum logic [3:0] {
		MODE_SPI_M4 = 4'h0,
		MODE_SPI_M16 = 4'h1,
		MODE_SPI_M64 = 4'h2,
		MODE_SPI_MTMR = 4'h3,
		MODE_SPI_S_SS = 4'h4,
		MODE_SPI_S_NOSS = 4'h5,
		MODE_I2C_S7 = 4'h6,
		MODE_I2C_S10 = 4'h7,
		MODE_I2C_FWM = 4'hB,
		MODE_I2C_S7_INT = 4'hE,
		MODE_I2C_S10_INT = 4'hF
	} sspc_mode_type;
	// events reported by the link-side shifter
	typedef struct packed {
		logic byte_done;
		logic byte_is_data;
		logic start_seen;
		logic stop_seen;
		logic ack_seen;
		logic addr_match;
		logic addr_rw;
		logic addr_high_byte;
		logic tx_start;
		logic tx_done;
	} sspc_link_evt_type;
	// pin hand-over to the port: owned-by-port flag per pin, port output value for clock and data out
	typedef struct packed {
		logic sck_own;
		logic sck_out;
		logic sdo_own;
		logic sdo_out;
		logic sdi_own;
		logic ss_own;
	} sspc_pin_type;
endpackage

// ==== sim/sspc_ctrl_assertions.sv ====
// checker: port-level assertions of the serial port control block
`timescale 1ns/1ps
module sspc_ctrl_assertions
	import sspc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire sspc_pkg::sspc_link_evt_type link_evt,
	input wire logic [3:0] port_mode_select,
	input wire logic link_is_i2c,
	input wire logic link_is_master,
	input wire logic master_bit_tick,
	input wire logic cond_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic irq_mode;
	assign irq_mode = port_mode_select inside {MODE_I2C_S7_INT, MODE_I2C_S10_INT};
	////////////////////////////////
	mode_kind_a:
		assert property (link_is_i2c == (port_mode_select inside {4'h6, 4'h7, 4'hB, 4'hE, 4'hF}))
		else $error("i2c flag does not follow mode");
	// reset copies read zero, so only a fresh mode is judged
	master_codes_a:
		assert property ($changed(port_mode_select) && port_mode_select < 4'h4 |-> link_is_master)
		else $error("master code without master operation");
	slave_codes_a:
		assert property (port_mode_select inside {4'h4, 4'h5} |-> !link_is_master)
		else $error("slave code with master operation");
	tick_master_a:
		assert property (master_bit_tick |-> $past(link_is_master))
		else $error("bit tick outside master operation");
	irq_cause_a:
		assert property (cond_irq |-> $past(link_evt.start_seen || link_evt.stop_seen))
		else $error("condition pulse without start or stop");
	irq_mode_a:
		assert property (cond_irq |-> $past(irq_mode))
		else $error("condition pulse in a mode without it");
	irq_fire_a:
		assert property (link_evt.start_seen && irq_mode |=> cond_irq)
		else $error("start in pulse mode gave no pulse");
	err_zero_a:
		assert property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read returned data");
	upper_zero_a:
		assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	irq_seen_c: cover property (cond_irq);
	tick_seen_c: cover property (master_bit_tick);
	slverr_c: cover property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR);
endmodule
bind sspc_ctrl sspc_ctrl_assertions chk_i (.aclk, .aresetn, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .link_evt, .port_mode_select, .link_is_i2c, .link_is_master,
	.master_bit_tick, .cond_irq);

// ==== sim/sspc_link_model.sv ====
// link-side partner: shifter event pulses and timer two pulses
`timescale 1ns/1ps
module sspc_link_model
	import sspc_pkg::*;
#(
	parameter int TIMER_DIV = 8
)
(
	input wire logic aclk,
	output sspc_pkg::sspc_link_evt_type link_evt,
	output logic [7:0] link_rx_byte,
	output logic timer_two_output
);
	int cnt = 0;
	initial begin
		link_evt = '0;
		link_rx_byte = 8'h00;
		timer_two_output = 1'b0;
	end
	// free-running source for the timer-derived bit clock
	always @(posedge aclk) begin
		cnt <= (cnt == TIMER_DIV - 1) ? 0 : cnt + 1;
		timer_two_output <= cnt == TIMER_DIV - 1;
	end
	// byte lane shows inverted value outside its strobe, never a stale copy
	task automatic ev(input logic [9:0] e, input logic [7:0] b);
		link_evt <= e;
		link_rx_byte <= b;
		@(posedge aclk);
		link_evt <= '0;
		link_rx_byte <= ~b;
		@(posedge aclk);
	endtask
endmodule

// ==== sim/test_sync_serial_port_control.sv ====
// bench: register access over AXI4-Lite driven against link events
`timescale 1ns/1ps
module test_sync_serial_port_control;
	import sspc_pkg::*;
	localparam logic [9:0] E_BD = 10'h200, E_DAT = 10'h100, E_STA = 10'h080, E_STO = 10'h040;
	localparam logic [9:0] E_MAT = 10'h010, E_RW = 10'h008, E_TXS = 10'h002, E_TXD = 10'h001;
	logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	sspc_link_evt_type link_evt;
	logic [7:0] link_rx_byte, tx_byte;
	logic timer_two_output, link_is_i2c, link_is_master;
	sspc_pin_type pin_ctl;
	logic [3:0] port_mode_select;
	int err_total = 0, tests_run = 0;
	logic cond_irq, tx_load, master_bit_tick;
	logic [7:0] slave_address;
	// pulse outputs are counted so that no check lands on the edge that launches them
	int irq_cnt = 0, load_cnt = 0, tick_cnt = 0, tick_mark = 0;
	always #2 aclk = ~aclk;
	sspc_ctrl DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .link_evt, .link_rx_byte, .timer_two_output, .pin_ctl,
		.port_mode_select, .link_is_i2c, .link_is_master, .master_bit_tick, .tx_byte,
		.tx_load, .slave_address, .cond_irq);
	sspc_link_model lm (.aclk, .link_evt, .link_rx_byte, .timer_two_output);
	always @(posedge aclk) begin
		if (cond_irq) irq_cnt <= irq_cnt + 1;
		if (tx_load) load_cnt <= load_cnt + 1;
		if (master_bit_tick) tick_cnt <= tick_cnt + 1;
	end
	////////////////////////////////
	// two extra bits carry the response code alongside the read word
	task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid);
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		chk("bresp", s_axi_bresp, AXI_OKAY);
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk($sformatf("reg %h", a), {rr, rv & m}, {AXI_OKAY, e});
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(SSPC_CTRL_OFS, 32'hFF, 32'h00);
		rchk(SSPC_STAT_OFS, 32'hFF, 32'h00);
		wr(SSPC_CTRL_OFS, 32'h36);
		lm.ev(E_STA, 8'h00);
		chk("pins", pin_ctl & 6'h32, 32'h32);
		chk("mode", {port_mode_select, link_is_i2c}, 5'h0D);
		rchk(SSPC_STAT_OFS, 32'hFF, 32'h08);
		lm.ev(E_MAT | E_RW, 8'h00);
		rchk(SSPC_STAT_OFS, 32'hFF, 32'h0C);
		lm.ev(E_BD | E_DAT, 8'h5A);
		rchk(SSPC_STAT_OFS, 32'hFF, 32'h2D);
		rchk(SSPC_DATA_OFS, 32'hFF, 32'h5A);
		rchk(SSPC_STAT_OFS, 32'h01, 32'h00);
		lm.ev(E_BD | E_DAT, 8'h11);
		lm.ev(E_BD | E_DAT, 8'h22);
		rchk(SSPC_CTRL_OFS, 32'hFF, 32'h76);
		wr(SSPC_CTRL_OFS, 32'h36);
		rchk(SSPC_CTRL_OFS, 32'hFF, 32'h36);
		lm.ev(E_STO, 8'h00);
		rchk(SSPC_STAT_OFS, 32'h1C, 32'h10);
		wr(SSPC_CTRL_OFS, 32'h16);
		rchk(SSPC_STAT_OFS, 32'h18, 32'h00);
		chk("pins off", pin_ctl & 6'h2A, 32'h00);
		$display("test i2c flags done");
		wr(SSPC_CTRL_OFS, 32'h37);
		lm.ev(E_MAT, 8'h00);
		rchk(SSPC_STAT_OFS, 32'h02, 32'h02);
		wr(SSPC_ADDR_OFS, 32'h6E);
		rchk(SSPC_STAT_OFS, 32'h02, 32'h00);
		chk("slave address", slave_address, 32'h6E);
		$display("test address refresh done");
		foreach (codes[i]) begin
			wr(SSPC_CTRL_OFS, {28'h2, codes[i]});
			lm.ev(E_STA, 8'h00);
			chk("mode", port_mode_select, codes[i]);
			chk("i2c", link_is_i2c, codes[i] > 4'h5);
			if (codes[i] != 4'hB) chk("master", link_is_master, codes[i] < 4'h4);
		end
		$display("test mode codes done");
		wr(SSPC_CTRL_OFS, 32'h24);
		chk("irq pulses", irq_cnt, 32'h2);
		tick_mark = tick_cnt;
		rd(SSPC_DATA_OFS);
		lm.ev(E_BD, 8'h33);
		lm.ev(E_BD, 8'h44);
		rchk(SSPC_CTRL_OFS, 32'hFF, 32'h64);
		chk("idle ticks", tick_cnt, tick_mark);
		wr(SSPC_CTRL_OFS, 32'h20);
		rd(SSPC_DATA_OFS);
		lm.ev(E_BD, 8'h55);
		lm.ev(E_BD, 8'h66);
		rchk(SSPC_CTRL_OFS, 32'hFF, 32'h20);
		chk("run ticks", tick_cnt > tick_mark, 32'h1);
		$display("test link overflow done");
		wr(SSPC_DATA_OFS, 32'h81);
		lm.ev(E_TXS, 8'h00);
		chk("tx", {tx_byte, pin_ctl.sdo_out}, 9'h103);
		wr(SSPC_DATA_OFS, 32'h82);
		rchk(SSPC_CTRL_OFS, 32'hFF, 32'hA0);
		lm.ev(E_TXD, 8'h00);
		wr(SSPC_CTRL_OFS, 32'h20);
		wr(SSPC_DATA_OFS, 32'h83);
		rchk(SSPC_CTRL_OFS, 32'h80, 32'h00);
		chk("data loads", load_cnt, 32'h2);
		rd(8'h40);
		chk("unmapped", {rr, rv}, {AXI_SLVERR, 32'h0});
		$display("test collision and unmapped done");
		give_verdict;
	end
	// whole run needs a few hundred cycles; 50000 marks a hang
	initial begin
		#200000;
		err_total++;
		give_verdict;
	end
endmodule
